// ==== bench/asft_host_model.sv ====
// Host serial port model: select, frame sync, serial clock and data in.
// Assumes the bench clock; every pin moves 2 ns after a rising clock edge.
`timescale 1ns/1ps

module asft_host_model (
    input wire logic clk,
    output logic cs_n,
    output logic frame_sync_strobe,
    output logic sclk,
    output logic sdi,
    input wire logic sdo_o,
    input wire logic sdo_oe
);
    // Set when the serial output was not driven while a bit was read
    logic oe_bad;

    // Idle pins: deselected, sync high, serial clock still
    initial begin
        cs_n = 1'h1;
        frame_sync_strobe = 1'h1;
        sclk = 1'h0;
        sdi = 1'h0;
        oe_bad = 1'h0;
    end

    // Wait n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // One 160 ns serial period: data set at the rise, output read just before the fall
    task automatic bit_period(input logic d, output logic q);
        sclk = 1'h1;
        sdi = d;
        tick(4);
        q = sdo_o;
        oe_bad = oe_bad | (sdo_oe !== 1'h1);
        sclk = 1'h0;
        tick(4);
    endtask

    // Serial clock periods outside a frame, data toggling so nothing sticks
    task automatic spin(input int n);
        for (int i = 0; i < n; i++) begin
            sclk = 1'h1;
            sdi = ~sdi;
            tick(4);
            sclk = 1'h0;
            tick(4);
        end
    endtask

    // A whole frame; select mode deselects after the last edge
    task automatic frame(input logic fs_mode, input logic [15:0] cmd, input int edges, output logic [63:0] rx);
        logic q;
        rx = 64'h0;
        if (fs_mode) begin
            frame_sync_strobe = 1'h0;
            tick(1);
            cs_n = 1'h0;
            tick(8);
            frame_sync_strobe = 1'h1;
        end else begin
            cs_n = 1'h0;
            tick(8);
        end
        for (int i = 0; i < edges; i++) begin
            bit_period((i < 16) ? cmd[15 - i] : 1'h0, q);
            frame_sync_strobe = fs_mode ? 1'h0 : 1'h1;
            rx = {rx[62:0], q};
        end
        if (!fs_mode) begin
            cs_n = 1'h1;
            sdi = ~sdi;
        end
    endtask

    // Deselect first, then park sync high, so no sync edge is seen selected
    task automatic release_bus();
        cs_n = 1'h1;
        sdi = ~sdi;
        tick(1);
        frame_sync_strobe = 1'h1;
    endtask
endmodule

// ==== bench/asft_tb.sv ====
// Self-checking bench of the serial frame and conversion trigger block.
// Assumes the host model file is compiled first.
`timescale 1ns/1ps

module adc_serial_frame_trigger_tb_top;
    localparam int LIMIT = 20000; // Cycle ceiling of the whole run
    logic clk, reset_n, clk_en, cs_n, frame_sync_strobe, sclk, sdi, sdo_o, sdo_oe, int_n, eoc;
    logic long_sampling, conv_clk_sclk, res_14bit, result_valid, result_ready, cmd_valid;
    logic [15:0] result_data, cmd_data, cmd_last;
    int failures, checks, cycles, cmd_count;

    asft_top dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .cs_n(cs_n),
        .frame_sync_strobe(frame_sync_strobe), .sclk(sclk), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
        .int_n(int_n), .eoc(eoc), .long_sampling(long_sampling), .conv_clk_sclk(conv_clk_sclk),
        .res_14bit(res_14bit), .result_valid(result_valid), .result_ready(result_ready),
        .result_data(result_data), .cmd_data(cmd_data), .cmd_valid(cmd_valid));
    asft_host_model host (.clk(clk), .cs_n(cs_n), .frame_sync_strobe(frame_sync_strobe), .sclk(sclk),
        .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe));

    // 50 MHz clock
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // Command capture monitor and run ceiling
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cmd_valid === 1'h1) begin
            cmd_count = cmd_count + 1;
            cmd_last = cmd_data;
        end
        if (cycles == LIMIT) begin
            failures = failures + 1;
            give_verdict();
        end
    end

    // Counts, verdict and end of run
    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Compare of a word or a single bit
    task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // Compare of a count against a window
    task automatic check_count(input int got, input int lo, input int hi, input string msg);
        checks++;
        if (got < lo || got > hi) begin
            failures++;
            $display("[FAIL] %0t %s: got %0d expected %0d to %0d", $time, msg, got, lo, hi);
        end
    endtask

    // Mode straps and clock enable, set together between frames
    task automatic set_mode(input logic en, input logic ls, input logic cc);
        clk_en = en;
        long_sampling = ls;
        conv_clk_sclk = cc;
    endtask

    // Result source: push valid and word
    task automatic drive_result(input logic v, input logic [15:0] d);
        result_valid = v;
        result_data = d;
    endtask

    // Result word pattern
    function automatic logic [15:0] word(input int i);
        return 16'h8421 ^ (16'h1357 * i[15:0]);
    endfunction

    // Oscillator-timed conversion: eoc low, then interrupt after the set count
    task automatic conv_osc(input logic r14);
        int n, exp;
        n = 0;
        exp = r14 ? asft_pkg::CONV_OSC_CYC_14 : asft_pkg::CONV_OSC_CYC_12;
        check_word(eoc, 1'h0, "eoc not low in conversion");
        check_word(int_n, 1'h1, "interrupt not released");
        while (int_n !== 1'h0 && n < 400) begin
            host.tick(1);
            n++;
        end
        check_count(n, exp - 2, exp, "oscillator conversion length");
        check_word(eoc, 1'h1, "eoc not back high");
    endtask

    // Serial-clock-timed conversion: interrupt exactly at the last counted fall
    task automatic conv_sclk(input logic r14);
        int n;
        n = r14 ? asft_pkg::CONV_SCLK_PERIODS_14 : asft_pkg::CONV_SCLK_PERIODS_12;
        check_word(int_n, 1'h1, "interrupt not released by sync");
        host.spin(n - 1);
        check_word(int_n, 1'h1, "conversion ended early");
        check_word(eoc, 1'h0, "eoc not low in conversion");
        host.spin(1);
        check_word(int_n, 1'h0, "conversion not done");
        check_word(eoc, 1'h1, "eoc not back high");
    endtask

    // Fill the buffer until it refuses, then drain it through select frames
    task automatic sc_fill_drain();
        logic [63:0] rx;
        set_mode(1'h1, 1'h0, 1'h0);
        for (int i = 0; i < 16; i++) begin
            check_word(result_ready, 1'h1, "buffer refused early");
            drive_result(1'h1, word(i));
            host.tick(1);
        end
        drive_result(1'h0, 16'h0000);
        check_word(result_ready, 1'h0, "buffer not full at 16");
        for (int i = 0; i < 17; i++) begin
            res_14bit = i[0];
            host.frame(1'h0, ~word(i), 16, rx);
            check_word(rx[15:0], (i < 16) ? word(i) : 16'h0000, "result word");
            check_word(cmd_last, ~word(i), "command word");
            conv_osc(i[0]);
        end
        check_word(result_ready, 1'h1, "buffer still full");
        check_count(cmd_count, 17, 17, "command count");
        check_word(host.oe_bad, 1'h0, "output not driven in frame");
    endtask

    // Sync-started long frames with serial-clock conversion, both variants
    task automatic sc_fs_long();
        logic [63:0] rx;
        set_mode(1'h1, 1'h1, 1'h1);
        for (int r = 0; r < 2; r++) begin
            res_14bit = r[0];
            drive_result(1'h1, word(20 + r));
            host.tick(1);
            drive_result(1'h0, word(20 + r));
            host.frame(1'h1, 16'h5a0f, 48, rx);
            check_word(rx[47:32], word(20 + r), "result word");
            check_word(rx[31:16], 16'h0000, "zeros after result");
            check_word(cmd_last, 16'h5a0f, "command word");
            conv_sclk(r[0]);
            host.release_bus();
        end
    endtask

    // Select raised mid-frame aborts; serial clock is ignored while deselected
    task automatic sc_abort();
        logic [63:0] rx;
        int c0;
        c0 = cmd_count;
        set_mode(1'h1, 1'h0, 1'h0);
        host.frame(1'h0, 16'h1234, 5, rx);
        host.spin(20);
        host.tick(150);
        check_word(sdo_oe, 1'h0, "output driven while deselected");
        check_word(eoc, 1'h1, "conversion after abort");
        check_word(int_n, 1'h1, "interrupt after abort");
        check_count(cmd_count - c0, 0, 0, "command taken while deselected");
        host.frame(1'h0, 16'hc33c, 16, rx);
        check_word(cmd_last, 16'hc33c, "command after abort");
        conv_osc(res_14bit);
    endtask

    // Enable held low mid-conversion holds it; the rest then ends within the normal count window
    task automatic sc_freeze();
        logic [63:0] rx;
        set_mode(1'h1, 1'h0, 1'h0);
        host.frame(1'h0, 16'h0ff0, 16, rx);
        check_word(cmd_last, 16'h0ff0, "command before freeze");
        set_mode(1'h0, 1'h0, 1'h0);
        host.tick(60);
        check_word(int_n, 1'h1, "interrupt while frozen");
        check_word(eoc, 1'h0, "eoc moved while frozen");
        set_mode(1'h1, 1'h0, 1'h0);
        conv_osc(res_14bit);
    endtask

    // Reset, then the scenarios in turn
    initial begin
        failures = 0;
        checks = 0;
        cycles = 0;
        cmd_count = 0;
        cmd_last = 16'h0000;
        reset_n = 1'h0;
        set_mode(1'h1, 1'h0, 1'h0);
        res_14bit = 1'h1;
        drive_result(1'h0, 16'h0000);
        host.tick(3);
        reset_n = 1'h1;
        host.tick(4);
        check_word(int_n, 1'h1, "interrupt reset level");
        check_word(eoc, 1'h1, "eoc reset level");
        sc_fill_drain();
        sc_fs_long();
        sc_abort();
        sc_freeze();
        give_verdict();
    end
endmodule

// ==== rtl/asft_pkg.sv ====
// Package for the serial frame and conversion trigger block.
// Assumes a 50 MHz system clock and host pins sampled through synchronisers.
package asft_pkg;

    // Frame controller states
    typedef enum logic [1:0] {
        ASFT_IDLE,
        ASFT_SAMPLE,
        ASFT_CONVERT
    } asft_state_t;

    // System clock period
    localparam int CLK_PERIOD_NS = 20;

    // Serial word layout
    localparam int WORD_BITS = 16;
    localparam int WORD_MSB = 15;

    // Falling edges that end sampling in short and long frames
    localparam logic [5:0] SHORT_FRAME_EDGES = 6'h10;
    localparam logic [5:0] LONG_FRAME_EDGES = 6'h30;

    // Internal oscillator period, a plain default
    localparam int INTERNAL_OSCILLATOR_PERIOD_NS = 100;

    // Conversion length in oscillator periods, per variant
    localparam int CONV_OSC_PERIODS_14 = 18;
    localparam int CONV_OSC_PERIODS_12 = 13;

    // Fixed delay added to every oscillator-timed conversion
    localparam int CONV_EXTRA_NS = 15;

    // Conversion length in system clocks, least time rounded up
    localparam int CONV_OSC_CYC_14 =
        (CONV_OSC_PERIODS_14 * INTERNAL_OSCILLATOR_PERIOD_NS + CONV_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_OSC_CYC_12 =
        (CONV_OSC_PERIODS_12 * INTERNAL_OSCILLATOR_PERIOD_NS + CONV_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Conversion length in serial clock periods, per variant
    localparam int CONV_SCLK_PERIODS_14 = 72;
    localparam int CONV_SCLK_PERIODS_12 = 52;

    // Reset values of the outputs
    localparam logic INT_N_RESET = 1'b1;
    localparam logic EOC_RESET = 1'b1;

    // Result buffer defaults
    localparam int FIFO_DEPTH_DEFAULT = 16;

endpackage

// ==== rtl/asft_top.sv ====
// Serial host framing, sampling and conversion sequencing of a converter,
// plus the result buffer that feeds the serial output.
// Assumes host pins are asynchronous to clk and the analog core is outside.
`timescale 1ns/1ps

// Result buffer between the converter side and the serial shifter
module asft_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // Pointer and occupancy state
    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic in_ready;
        logic out_valid;
    } asft_fifo_regs_t;

    asft_fifo_regs_t cur_ff;
    asft_fifo_regs_t nxt_ff;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // Handshakes on both sides
    assign push = in_valid && cur_ff.in_ready;
    assign pop = out_ready && cur_ff.out_valid;
    assign in_ready = cur_ff.in_ready;
    assign out_valid = cur_ff.out_valid;
    assign out_data = mem[cur_ff.rd_ptr];

    // Next pointers and flags
    always_comb begin
        nxt_ff = cur_ff;
        if (push) begin
            nxt_ff.wr_ptr = (cur_ff.wr_ptr == AW'(DEPTH - 1)) ? '0 : cur_ff.wr_ptr + 1'b1;
        end
        if (pop) begin
            nxt_ff.rd_ptr = (cur_ff.rd_ptr == AW'(DEPTH - 1)) ? '0 : cur_ff.rd_ptr + 1'b1;
        end
        // Occupancy moves only on a lone push or pop
        if (push && !pop) begin
            nxt_ff.count = cur_ff.count + 1'b1;
        end else if (pop && !push) begin
            nxt_ff.count = cur_ff.count - 1'b1;
        end
        nxt_ff.in_ready = (nxt_ff.count != (AW + 1)'(DEPTH));
        nxt_ff.out_valid = (nxt_ff.count != '0);
    end

    // State register, frozen while the enable is low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_ff <= '{wr_ptr: '0, rd_ptr: '0, count: '0, in_ready: 1'b1, out_valid: 1'b0};
        end else if (clk_en) begin
            cur_ff <= nxt_ff;
        end
    end

    // Storage write
    always_ff @(posedge clk) begin
        if (clk_en && push) begin
            mem[cur_ff.wr_ptr] <= in_data;
        end
    end
endmodule

// Frame controller for the host serial port
module asft_top #(
    parameter int FIFO_DEPTH = asft_pkg::FIFO_DEPTH_DEFAULT,
    parameter int WORD_W = asft_pkg::WORD_BITS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic cs_n,
    input wire logic frame_sync_strobe,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo_o,
    output logic sdo_oe,
    output logic int_n,
    output logic eoc,
    input wire logic long_sampling,
    input wire logic conv_clk_sclk,
    input wire logic res_14bit,
    input wire logic result_valid,
    output logic result_ready,
    input wire logic [WORD_W-1:0] result_data,
    output logic [WORD_W-1:0] cmd_data,
    output logic cmd_valid
);
    // All registered state of the controller
    typedef struct packed {
        logic [2:0] cs_sy;
        logic [2:0] fs_sy;
        logic [2:0] sclk_sy;
        logic [1:0] sdi_sy;
        asft_pkg::asft_state_t st;
        logic [5:0] edge_cnt;
        logic [WORD_W-1:0] out_sh;
        logic [WORD_W-1:0] in_sh;
        logic [15:0] conv_cnt;
        logic sdo;
        logic sdo_oe;
        logic int_n;
        logic eoc;
        logic [WORD_W-1:0] cmd;
        logic cmd_valid;
        logic pop;
    } asft_regs_t;

    asft_regs_t cur_ff;
    asft_regs_t nxt_ff;

    // Buffer head towards the shifter
    logic head_valid;
    logic [WORD_W-1:0] head_data;

    // Synchronised levels and edges, frame start, and conversion length and count terms
    logic cs_low;
    logic fs_high;
    logic cs_fall;
    logic fs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_start;
    logic [5:0] edge_limit;
    logic [15:0] conv_target;
    logic conv_tick;
    logic conv_done;

    asft_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .in_valid(result_valid),
        .in_ready(result_ready),
        .in_data(result_data),
        .out_valid(head_valid),
        .out_ready(cur_ff.pop),
        .out_data(head_data)
    );

    // Second and third flops only; the first stage feeds nothing else
    assign cs_low = !cur_ff.cs_sy[1];
    assign fs_high = cur_ff.fs_sy[1];
    assign cs_fall = cur_ff.cs_sy[2] && !cur_ff.cs_sy[1];
    assign fs_rise = !cur_ff.fs_sy[2] && cur_ff.fs_sy[1];
    assign sclk_rise = !cur_ff.sclk_sy[2] && cur_ff.sclk_sy[1];
    assign sclk_fall = cur_ff.sclk_sy[2] && !cur_ff.sclk_sy[1];

    // Frame starts: select edge with sync high, or sync edge while selected
    assign frame_start = (cur_ff.st == asft_pkg::ASFT_IDLE) &&
        ((cs_fall && fs_high) || (fs_rise && cs_low));

    // Sampling window length
    assign edge_limit = long_sampling ? asft_pkg::LONG_FRAME_EDGES : asft_pkg::SHORT_FRAME_EDGES;

    // Conversion length in the selected conversion clock
    always_comb begin
        if (conv_clk_sclk) begin
            conv_target = res_14bit ? 16'(asft_pkg::CONV_SCLK_PERIODS_14) : 16'(asft_pkg::CONV_SCLK_PERIODS_12);
        end else begin
            conv_target = res_14bit ? 16'(asft_pkg::CONV_OSC_CYC_14) : 16'(asft_pkg::CONV_OSC_CYC_12);
        end
    end

    // Serial clock mode counts falling edges, oscillator mode every clock
    assign conv_tick = conv_clk_sclk ? sclk_fall : 1'b1;
    assign conv_done = (cur_ff.st == asft_pkg::ASFT_CONVERT) && conv_tick &&
        (cur_ff.conv_cnt == conv_target - 16'h0001);

    // Next-state logic of the whole controller
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.cs_sy = {cur_ff.cs_sy[1:0], cs_n};
        nxt_ff.fs_sy = {cur_ff.fs_sy[1:0], frame_sync_strobe};
        nxt_ff.sclk_sy = {cur_ff.sclk_sy[1:0], sclk};
        nxt_ff.sdi_sy = {cur_ff.sdi_sy[0], sdi};
        nxt_ff.cmd_valid = 1'b0;
        nxt_ff.pop = 1'b0;
        // Output driven only while selected
        nxt_ff.sdo_oe = cs_low;
        // Either frame edge releases the interrupt
        if ((cs_fall && fs_high) || (fs_rise && cs_low)) begin
            nxt_ff.int_n = 1'b1;
        end
        case (cur_ff.st)
            asft_pkg::ASFT_IDLE: begin
                // New frame: load the buffer head, MSB out at once
                if (frame_start) begin
                    nxt_ff.st = asft_pkg::ASFT_SAMPLE;
                    nxt_ff.edge_cnt = '0;
                    nxt_ff.out_sh = head_valid ? head_data : '0;
                    nxt_ff.sdo = head_valid ? head_data[WORD_W-1] : 1'b0;
                    nxt_ff.pop = head_valid;
                end
            end
            asft_pkg::ASFT_SAMPLE: begin
                if (!cs_low) begin
                    // Select lost mid-sampling: abandon frame
                    nxt_ff.st = asft_pkg::ASFT_IDLE;
                end else if (sclk_fall) begin
                    nxt_ff.edge_cnt = cur_ff.edge_cnt + 6'h01;
                    if (cur_ff.edge_cnt < asft_pkg::SHORT_FRAME_EDGES) begin
                        nxt_ff.in_sh = {cur_ff.in_sh[WORD_W-2:0], cur_ff.sdi_sy[1]};
                    end
                    if (cur_ff.edge_cnt == asft_pkg::SHORT_FRAME_EDGES - 6'h01) begin
                        nxt_ff.cmd = {cur_ff.in_sh[WORD_W-2:0], cur_ff.sdi_sy[1]};
                        nxt_ff.cmd_valid = 1'b1;
                    end
                    // Last sampling edge starts conversion
                    if (cur_ff.edge_cnt == edge_limit - 6'h01) begin
                        nxt_ff.st = asft_pkg::ASFT_CONVERT;
                        nxt_ff.eoc = 1'b0;
                        nxt_ff.conv_cnt = '0;
                    end
                end else if (sclk_rise && cur_ff.edge_cnt != '0) begin
                    // Next bit goes out after the rising edge
                    nxt_ff.out_sh = {cur_ff.out_sh[WORD_W-2:0], 1'b0};
                    nxt_ff.sdo = cur_ff.out_sh[WORD_W-2];
                end
            end
            asft_pkg::ASFT_CONVERT: begin
                // Conversion keeps running even if select rises
                if (conv_done) begin
                    nxt_ff.st = asft_pkg::ASFT_IDLE;
                    nxt_ff.int_n = 1'b0;
                    nxt_ff.eoc = 1'b1;
                end else if (conv_tick) begin
                    nxt_ff.conv_cnt = cur_ff.conv_cnt + 16'h0001;
                end
            end
            default: begin
                nxt_ff.st = asft_pkg::ASFT_IDLE;
            end
        endcase
    end

    // State register, frozen while the enable is low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // Synchronisers start at the idle pin levels so no false edge follows reset
            cur_ff <= '{cs_sy: 3'h7, fs_sy: 3'h7, sclk_sy: 3'h0, sdi_sy: 2'h0, st: asft_pkg::ASFT_IDLE,
                edge_cnt: '0, out_sh: '0, in_sh: '0, conv_cnt: '0, sdo: 1'b0, sdo_oe: 1'b0,
                int_n: asft_pkg::INT_N_RESET, eoc: asft_pkg::EOC_RESET, cmd: '0, cmd_valid: 1'b0, pop: 1'b0};
        end else if (clk_en) begin
            cur_ff <= nxt_ff;
        end
    end

    // Outputs straight from the state register
    assign sdo_o = cur_ff.sdo;
    assign sdo_oe = cur_ff.sdo_oe;
    assign int_n = cur_ff.int_n;
    assign eoc = cur_ff.eoc;
    assign cmd_data = cur_ff.cmd;
    assign cmd_valid = cur_ff.cmd_valid;

    // Input bit is the synchronised level at the falling edge
    capture_bit_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && cur_ff.st == asft_pkg::ASFT_SAMPLE && cs_low && sclk_fall &&
        cur_ff.edge_cnt < asft_pkg::SHORT_FRAME_EDGES) |=> (cur_ff.in_sh[0] == $past(cur_ff.sdi_sy[1])))
        else $error("serial input bit not captured on falling edge");

    // Output bit moves only after a rising edge or a frame start
    launch_bit_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cur_ff.sdo != $past(cur_ff.sdo)) |-> $past(clk_en && (sclk_rise || frame_start)))
        else $error("serial output changed without a rising edge");

    // Final sampling edge enters conversion with end-of-conversion low
    conv_start_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && cur_ff.st == asft_pkg::ASFT_SAMPLE && cs_low && sclk_fall &&
        cur_ff.edge_cnt == edge_limit - 6'h01) |=> (cur_ff.st == asft_pkg::ASFT_CONVERT && !cur_ff.eoc))
        else $error("conversion did not start at final sampling edge");

    // Short frame never converts before sixteen edges
    short_edges_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cur_ff.st == asft_pkg::ASFT_SAMPLE ##1 cur_ff.st == asft_pkg::ASFT_CONVERT) |->
        ($past(cur_ff.edge_cnt) == edge_limit - 6'h01))
        else $error("conversion started at wrong edge count");

    // End-of-conversion stays low through conversion
    eoc_low_a: assert property (@(posedge clk) disable iff (!reset_n)
        (cur_ff.st == asft_pkg::ASFT_CONVERT) |-> !cur_ff.eoc)
        else $error("end-of-conversion high during conversion");

    // Oscillator conversion ends with the interrupt after the full count
    osc_time_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && !conv_clk_sclk && cur_ff.st == asft_pkg::ASFT_CONVERT &&
        cur_ff.conv_cnt == conv_target - 16'h0001) |=> (!cur_ff.int_n && cur_ff.st == asft_pkg::ASFT_IDLE))
        else $error("oscillator conversion length wrong");

    // Serial clock conversion count never passes its target
    sclk_time_a: assert property (@(posedge clk) disable iff (!reset_n)
        (conv_clk_sclk && cur_ff.st == asft_pkg::ASFT_CONVERT) |-> (cur_ff.conv_cnt < conv_target))
        else $error("serial clock conversion overran");

    // Output released whenever select is high
    deselect_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && !cs_low) |=> !cur_ff.sdo_oe)
        else $error("output driven while deselected");

    // Select falling edge raises the interrupt line
    cs_release_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && cs_fall && fs_high) |=> cur_ff.int_n)
        else $error("interrupt not released on select edge");

    // Frame sync rising edge raises the interrupt line
    fs_release_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && fs_rise && cs_low) |=> cur_ff.int_n)
        else $error("interrupt not released on frame sync edge");

    // First output bit is the buffer head MSB
    msb_first_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && frame_start) |=> (cur_ff.sdo == $past(head_valid && head_data[WORD_W-1])))
        else $error("first output bit not the MSB");

    // Edge counter advances by one per falling edge during sampling
    edge_count_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clk_en && cur_ff.st == asft_pkg::ASFT_SAMPLE && cs_low && sclk_fall) |=>
        (cur_ff.edge_cnt == $past(cur_ff.edge_cnt) + 6'h01))
        else $error("falling edge count did not advance");
endmodule
